// ==== design/crtiu_core.v ====
// Call, return and timer instruction unit
`timescale 1ns/1ps
`include "crtiu_regs.vh"
module crtiu_core (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_op_valid,
	input wire [7:0] i_op_byte,
	input wire i_halt_req,
	input wire i_bank_flip_flop,
	input wire [3:0] i_status_word_hi,
	input wire [7:0] i_accumulator,
	input wire i_test_zero_input,
	input wire i_test_one_input,
	output reg o_busy,
	output reg o_halted,
	output reg [11:0] o_program_counter,
	output reg [2:0] o_stack_pointer,
	output reg [3:0] o_status_word_hi,
	output reg o_status_load,
	output reg [7:0] o_acc_data,
	output reg o_acc_load,
	output reg [7:0] o_timer_count,
	output reg o_timer_flag,
	output reg o_timer_irq_en,
	output reg o_timer_irq
);
	reg [1:0] state_ff;
	reg [1:0] mode_ff;
	reg [4:0] pres_ff;
	reg [2:0] call_hi_ff;
	reg restore_ff;
	reg t1_prev_ff;
	reg flag_jump_ff;
	wire t0_s;
	wire t1_s;
	wire [15:0] pop_data;
	reg stk_we;
	reg [2:0] stk_raddr;
	reg tick;
	wire [11:0] pc_inc;
	wire [11:0] pc_inc2;
	wire wrap_now;
	assign wrap_now = tick && (o_timer_count == 8'hFF);
	assign pc_inc = o_program_counter + 12'h001;
	assign pc_inc2 = o_program_counter + 12'h002;
	crtiu_sync u_sync_t0 (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_test_zero_input),
		.o_sync(t0_s)
	);
	crtiu_sync u_sync_t1 (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_test_one_input),
		.o_sync(t1_s)
	);
	// Push in operand cycle of a call
	always @* begin
		stk_we = (state_ff == `CRTIU_ST_OPND) && i_op_valid;
		stk_raddr = o_stack_pointer - 3'h1;
	end
	crtiu_stack u_stack (
		.i_clk(i_clk),
		.i_we(stk_we),
		.i_waddr(o_stack_pointer),
		.i_wdata({i_status_word_hi, pc_inc}),
		.i_raddr(stk_raddr),
		.o_rdata(pop_data)
	);
	// Counting source per mode
	always @* begin
		case (mode_ff)
			`CRTIU_MODE_EVT: tick = t1_s && !t1_prev_ff;
			`CRTIU_MODE_TMR: tick = (pres_ff == `CRTIU_PRESCALE);
			default: tick = 1'b0;
		endcase
	end
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			state_ff <= `CRTIU_ST_EXEC;
			mode_ff <= `CRTIU_MODE_STOP;
			pres_ff <= 5'h00;
			call_hi_ff <= 3'h0;
			restore_ff <= 1'b0;
			t1_prev_ff <= 1'b0;
			flag_jump_ff <= 1'b0;
			o_busy <= 1'b0;
			o_halted <= 1'b0;
			o_program_counter <= 12'h000;
			o_stack_pointer <= 3'h0;
			o_status_word_hi <= 4'h0;
			o_status_load <= 1'b0;
			o_acc_data <= 8'h00;
			o_acc_load <= 1'b0;
			o_timer_count <= 8'h00;
			o_timer_flag <= 1'b0;
			o_timer_irq_en <= 1'b0;
			o_timer_irq <= 1'b0;
		end else begin
			t1_prev_ff <= t1_s;
			o_acc_load <= 1'b0;
			o_status_load <= 1'b0;
			pres_ff <= (mode_ff == `CRTIU_MODE_TMR) ? pres_ff + 5'h01 : 5'h00;
			if (tick) begin
				o_timer_count <= o_timer_count + 8'h01;
				if (o_timer_count == 8'hFF) begin
					o_timer_flag <= 1'b1;
					if (o_timer_irq_en) begin
						o_timer_irq <= 1'b1;
					end
				end
			end
			case (state_ff)
				`CRTIU_ST_EXEC: begin
					if (i_halt_req) begin
						state_ff <= `CRTIU_ST_HALT;
						o_halted <= 1'b1;
						o_busy <= 1'b1;
					end else if (flag_jump_ff && i_op_valid) begin
						flag_jump_ff <= 1'b0;
					end else if (i_op_valid) begin
						if (i_op_byte[4:0] == `CRTIU_OP_CALL_LOW) begin
							call_hi_ff <= i_op_byte[7:5];
							state_ff <= `CRTIU_ST_OPND;
							o_busy <= 1'b1;
							o_program_counter <= pc_inc;
						end else begin
							case (i_op_byte)
								`CRTIU_OP_PLAIN_RTN, `CRTIU_OP_RESTORE_RTN: begin
									restore_ff <= (i_op_byte == `CRTIU_OP_RESTORE_RTN);
									o_stack_pointer <= o_stack_pointer - 3'h1;
									state_ff <= `CRTIU_ST_POP;
									o_busy <= 1'b1;
								end
								`CRTIU_OP_TIRQ_EN: begin
									o_timer_irq_en <= 1'b1;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_TIRQ_DIS: begin
									o_timer_irq_en <= 1'b0;
									if (!wrap_now) begin
										o_timer_irq <= 1'b0;
									end
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_RD_TMR: begin
									o_acc_data <= o_timer_count;
									o_acc_load <= 1'b1;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_LD_TMR: begin
									o_timer_count <= i_accumulator;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_HALT_COUNT: begin
									mode_ff <= `CRTIU_MODE_STOP;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_START_EVT: begin
									mode_ff <= `CRTIU_MODE_EVT;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_START_TMR: begin
									mode_ff <= `CRTIU_MODE_TMR;
									o_program_counter <= pc_inc;
								end
								`CRTIU_OP_JUMP_FLAG: begin
									flag_jump_ff <= 1'b1;
									if (o_timer_flag && !wrap_now) begin
										o_timer_flag <= 1'b0;
									end
									if (o_timer_flag) begin
										state_ff <= `CRTIU_ST_OPND;
										call_hi_ff <= 3'h0;
										o_program_counter <= pc_inc;
									end else begin
										o_program_counter <= pc_inc2;
									end
								end
								default: begin
									o_program_counter <= pc_inc;
								end
							endcase
						end
					end
				end
				`CRTIU_ST_OPND: begin
					if (i_op_valid) begin
						state_ff <= `CRTIU_ST_EXEC;
						o_busy <= 1'b0;
						if (flag_jump_ff) begin
							flag_jump_ff <= 1'b0;
							o_program_counter[7:0] <= i_op_byte;
						end else begin
							o_stack_pointer <= o_stack_pointer + 3'h1;
							o_program_counter <= {i_bank_flip_flop, call_hi_ff,
								i_op_byte};
						end
					end
				end
				`CRTIU_ST_POP: begin
					o_program_counter <= pop_data[11:0];
					if (restore_ff) begin
						o_status_word_hi <= pop_data[15:12];
						o_status_load <= 1'b1;
					end
					state_ff <= `CRTIU_ST_EXEC;
					o_busy <= 1'b0;
				end
				`CRTIU_ST_HALT: begin
					if (t0_s) begin
						state_ff <= `CRTIU_ST_EXEC;
						o_halted <= 1'b0;
						o_busy <= 1'b0;
					end
				end
				default: state_ff <= `CRTIU_ST_EXEC;
			endcase
		end
	end
endmodule

// ==== design/crtiu_regs.vh ====
// Constants of the call, return and timer instruction unit
// Summary of operation
// - Call is two bytes, two cycles; first byte a10..a8 then 10100.
// - Call pushes PC and status 7..4 at pointer, bumps pointer, loads PC.
// - Call takes PC bit 11 from the bank flip-flop.
// - Plain return 0x83 pops PC only, status kept; two cycles.
// - Restoring return 0x93 pops PC and status 7..4; two cycles.
// - Opcode 0x25 enables the timer interrupt request.
// - Opcode 0x35 disables the timer interrupt; count unaffected.
// - Opcode 0x42 copies the timer value to the accumulator.
// - Opcode 0x62 loads the timer from the accumulator.
// - Opcode 0x65 stops counting in either mode.
// - Opcode 0x45 starts event counting on test-one input.
// - Opcode 0x55 starts timer mode from the internal clock.
// - Opcode 0x00 only advances the program counter.
// - Program addresses are twelve bits wide.
// - Timer register is eight bits wide.
// - Test-zero input wakes the unit from halt.
// - Test-one input is the event source in event mode.
// - Reset clears the system and releases halt.
// - Jump on timer flag loads PC 7..0 if set, else skips two.
`ifndef CRTIU_REGS_VH
`define CRTIU_REGS_VH
`define CRTIU_OP_CALL_LOW 5'h14
`define CRTIU_OP_PLAIN_RTN 8'h83
`define CRTIU_OP_RESTORE_RTN 8'h93
`define CRTIU_OP_TIRQ_EN 8'h25
`define CRTIU_OP_TIRQ_DIS 8'h35
`define CRTIU_OP_RD_TMR 8'h42
`define CRTIU_OP_LD_TMR 8'h62
`define CRTIU_OP_HALT_COUNT 8'h65
`define CRTIU_OP_START_EVT 8'h45
`define CRTIU_OP_START_TMR 8'h55
`define CRTIU_OP_IDLE 8'h00
`define CRTIU_OP_JUMP_FLAG 8'h16
`define CRTIU_PRESCALE 5'h1F
`define CRTIU_ST_EXEC 2'h0
`define CRTIU_ST_OPND 2'h1
`define CRTIU_ST_POP 2'h2
`define CRTIU_ST_HALT 2'h3
`define CRTIU_MODE_STOP 2'h0
`define CRTIU_MODE_EVT 2'h1
`define CRTIU_MODE_TMR 2'h2
`endif

// ==== design/crtiu_sync.v ====
// Two flip-flop input synchroniser
`timescale 1ns/1ps
module crtiu_sync (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_async,
	output reg o_sync
);
	reg meta_ff;
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			meta_ff <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta_ff <= i_async;
			o_sync <= meta_ff;
		end
	end
endmodule

// ==== design/crtiu_stack.v ====
// Eight entry return stack, registered read
`timescale 1ns/1ps
module crtiu_stack (
	input wire i_clk,
	input wire i_we,
	input wire [2:0] i_waddr,
	input wire [15:0] i_wdata,
	input wire [2:0] i_raddr,
	output reg [15:0] o_rdata
);
	reg [15:0] mem [0:7];
	always @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule

// ==== bench/crtiu_monitor.sv ====
// Checker for the call, return and timer unit
`timescale 1ns/1ps
module crtiu_monitor (
	input logic i_clk,
	input logic i_reset_n,
	input logic i_op_valid,
	input logic [7:0] i_op_byte,
	input logic [7:0] i_accumulator,
	input logic i_bank_flip_flop,
	input logic i_test_zero_input,
	input logic o_busy,
	input logic o_halted,
	input logic [11:0] o_program_counter,
	input logic [2:0] o_stack_pointer,
	input logic o_status_load,
	input logic [7:0] o_acc_data,
	input logic o_acc_load,
	input logic [7:0] o_timer_count,
	input logic o_timer_flag,
	input logic o_timer_irq_en
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_reset_n);
wire tk = i_op_valid && !o_busy;
wire [11:0] pc = o_program_counter;
wire [2:0] sp = o_stack_pointer;
reg [2:0] hi_ff;
always @(posedge i_clk) hi_ff <= i_op_byte[7:5];
sequence s_pop;
	o_busy && sp == $past(sp) - 3'h1;
endsequence
sequence s_call;
	tk && i_op_byte[4:0] == 5'h14 ##1 i_op_valid;
endsequence
AST_CALL: assert property (s_call |=> sp == $past(sp) + 3'h1 &&
	pc == {$past(i_bank_flip_flop), $past(hi_ff), $past(i_op_byte)})
	else $error("call target wrong");
AST_RET: assert property (tk && i_op_byte == 8'h83 |=>
	o_busy && sp == $past(sp) - 3'h1 && !o_status_load ##1 !o_status_load)
	else $error("plain return wrong");
AST_RESTORE: assert property (tk && i_op_byte == 8'h93 |=>
	s_pop ##1 o_status_load)
	else $error("restoring return wrong");
AST_IRQ_EN: assert property (tk && i_op_byte == 8'h25 |=>
	o_timer_irq_en)
	else $error("irq enable missed");
AST_IRQ_DIS: assert property (tk && i_op_byte == 8'h35 |=>
	!o_timer_irq_en)
	else $error("irq disable missed");
AST_RD_TMR: assert property (tk && i_op_byte == 8'h42 |=>
	o_acc_load && o_acc_data == $past(o_timer_count))
	else $error("timer read wrong");
AST_LD_TMR: assert property (tk && i_op_byte == 8'h62 |=>
	o_timer_count == $past(i_accumulator))
	else $error("timer load wrong");
AST_IDLE: assert property (tk && i_op_byte == 8'h00 |=>
	pc == $past(pc) + 12'h1)
	else $error("idle step wrong");
AST_WRAP: assert property (o_timer_count == 8'hFF &&
	!(tk && i_op_byte == 8'h62) ##1 o_timer_count == 8'h00 |-> o_timer_flag)
	else $error("wrap flag missed");
AST_WAKE: assert property ($rose(i_test_zero_input) && o_halted
	|-> ##[1:5] !o_halted)
	else $error("halt wake late");
endmodule
bind crtiu_core crtiu_monitor u_mon (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_op_valid(i_op_valid),
	.i_op_byte(i_op_byte),
	.i_accumulator(i_accumulator),
	.i_bank_flip_flop(i_bank_flip_flop),
	.i_test_zero_input(i_test_zero_input),
	.o_busy(o_busy),
	.o_halted(o_halted),
	.o_program_counter(o_program_counter),
	.o_stack_pointer(o_stack_pointer),
	.o_status_load(o_status_load),
	.o_acc_data(o_acc_data),
	.o_acc_load(o_acc_load),
	.o_timer_count(o_timer_count),
	.o_timer_flag(o_timer_flag),
	.o_timer_irq_en(o_timer_irq_en)
);

// ==== bench/crtiu_dp_model.sv ====
// Datapath model holding accumulator and status nibble
`timescale 1ns/1ps
module crtiu_dp_model (
	input logic i_clk,
	input logic [7:0] i_acc_data,
	input logic i_acc_load,
	input logic [3:0] i_status,
	input logic i_status_load,
	output logic [7:0] o_acc = 8'h00,
	output logic [3:0] o_status = 4'h0
);
always @(posedge i_clk) begin
	if (i_acc_load) o_acc <= i_acc_data;
	if (i_status_load) o_status <= i_status;
end
endmodule

// ==== bench/crtiu_core_test.sv ====
// Self-checking bench for the instruction unit
`timescale 1ns/1ps
module crtiu_core_test;
logic i_clk = 1'b0, rst_n = 1'b0, v = 1'b0, hreq = 1'b0, t0 = 1'b0, t1 = 1'b0;
logic bank = 1'b1;
logic [7:0] b = 8'h00, acc, acc_d, count, tc;
logic [3:0] st, st_d;
logic [11:0] pc, p;
logic [2:0] sp;
logic busy, hlt, st_ld, acc_ld, flag, ien, irq;
int bad_count = 0, n_tests = 0, cyc = 0;
crtiu_core u_dut (.i_clk(i_clk), .i_reset_n(rst_n), .i_op_valid(v),
	.i_op_byte(b), .i_halt_req(hreq), .i_bank_flip_flop(bank),
	.i_status_word_hi(st), .i_accumulator(acc), .i_test_zero_input(t0),
	.i_test_one_input(t1), .o_busy(busy), .o_halted(hlt),
	.o_program_counter(pc), .o_stack_pointer(sp), .o_status_word_hi(st_d),
	.o_status_load(st_ld), .o_acc_data(acc_d), .o_acc_load(acc_ld),
	.o_timer_count(count), .o_timer_flag(flag), .o_timer_irq_en(ien),
	.o_timer_irq(irq));
crtiu_dp_model u_dp (.i_clk(i_clk), .i_acc_data(acc_d), .i_acc_load(acc_ld),
	.i_status(st_d), .i_status_load(st_ld), .o_acc(acc), .o_status(st));
initial forever #10 i_clk = ~i_clk;
always @(posedge i_clk) begin
	cyc <= cyc + 1;
	if (cyc == 3000) begin
		bad_count++;
		finish_test;
	end
end
task chk(input logic [19:0] g, input logic [19:0] e);
	n_tests++;
	if (g !== e) begin
		bad_count++;
		$display("unexpected %0t got %h exp %h", $time, g, e);
	end
endtask
task op(input logic [7:0] x);
	@(negedge i_clk);
	v = 1'b1;
	b = x;
endtask
task gap(input int n);
	repeat (n) @(negedge i_clk) v = 1'b0;
endtask
task t_call;
	u_dp.o_status = 4'hA;
	op({3'h5, 5'h14});
	op(8'h3C);
	gap(1);
	chk({sp, pc}, 15'h1D3C);
	op(8'h00);
	u_dp.o_status = 4'h5;
	bank = 1'b0;
	op(8'h14);
	op(8'h10);
	gap(1);
	chk({sp, pc}, 15'h2010);
	op(8'h93);
	u_dp.o_status = 4'hC;
	gap(3);
	chk({st, sp, pc}, 19'h29D3F);
	u_dp.o_status = 4'h3;
	op(8'h83);
	gap(3);
	chk({st, sp, pc}, 19'h18002);
endtask
task t_timer;
	u_dp.o_acc = 8'hFE;
	op(8'h62);
	gap(1);
	chk(count, 8'hFE);
	op(8'h25);
	op(8'h55);
	gap(1);
	repeat (100) if (flag !== 1'b1) @(negedge i_clk);
	chk({flag, irq, count}, 10'h300);
	op(8'h65);
	gap(1);
	tc = count;
	repeat (40) @(negedge i_clk);
	chk(count, tc);
	op(8'h42);
	op(8'h35);
	gap(2);
	chk({acc, ien, irq}, {tc, 2'b00});
	p = pc;
	op(8'h16);
	op(8'h40);
	gap(1);
	chk({flag, pc}, {1'b0, p[11:8], 8'h40});
	op(8'h16);
	op(8'h77);
	gap(1);
	chk(pc, {p[11:8], 8'h42});
endtask
task t_event;
	u_dp.o_acc = 8'h10;
	op(8'h62);
	op(8'h45);
	gap(1);
	repeat (3) begin
		t1 = 1'b1;
		repeat (4) @(negedge i_clk);
		t1 = 1'b0;
		repeat (4) @(negedge i_clk);
	end
	chk(count, 8'h13);
endtask
task hp;
	@(negedge i_clk) hreq = 1'b1;
	@(negedge i_clk) hreq = 1'b0;
	@(negedge i_clk);
endtask
task t_halt;
	hp;
	chk(hlt, 1'b1);
	t0 = 1'b1;
	repeat (8) @(negedge i_clk);
	chk(hlt, 1'b0);
	t0 = 1'b0;
	hp;
	rst_n = 1'b0;
	@(negedge i_clk) chk({hlt, pc}, 13'h0);
	rst_n = 1'b1;
	op(8'h00);
	gap(1);
	chk({hlt, pc}, 13'h0001);
endtask
task finish_test;
	$display("checks %0d mismatches %0d", n_tests, bad_count);
	if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
	else $display("[ FAIL ]");
	$finish;
endtask
initial begin
	repeat (16) @(negedge i_clk);
	rst_n = 1'b1;
	t_call;
	t_timer;
	t_event;
	t_halt;
	finish_test;
end
endmodule
